//--- hw/itd_pkg.sv
// Purpose: constants and types for the interrupt task dispatcher
// Assumes: 50 MHz clock, AXI4-Lite register access
// Notes: register offsets are byte addresses
// Notes on behaviour
// - Power-off task runs only when enabled
// - Zero delay: power-off task cut at 10 ms
// - Nonzero delay: window is 10 ms minus delay
// - Delay field bits 0-7, 0-10 ms, default 0
// - Start power-off after detection time plus delay
// - No power-off task during online editing
// - Power-off aborts running task, no resume
// - Other interrupts wait pending, no nesting
// - Clear-pending drops saved I/O requests only
// - Priority: I/O, then external, then scheduled
// - Same type: lowest task number first
// - One pending record; ignore running task's request
// - External tasks 0-255 always accepted
// - Shared numbers run the same task
// - Record longest task time, 0.1 ms units
// - Longest-time task number 8000-80FF, cleared at start
// - Error flag set when detection enabled
// - Capture erroring task number, 12 bits
`default_nettype none
package itd_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned CUTOFF_MS = 10;
	localparam int unsigned DELAY_MAX = 10;
	localparam int unsigned TICK_US = 100;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned MS_CYC = CLK_HZ / 1000;
	localparam logic [3:0] A_SETUP = 4'h0;
	localparam logic [3:0] A_MAXTIME = 4'h4;
	localparam logic [3:0] A_MAXTASK = 4'h8;
	localparam logic [3:0] A_ERRNUM = 4'hC;
	localparam int unsigned EN_BIT = 15;
	localparam int unsigned ONLINE_BIT = 14;
	localparam int unsigned ERRDET_BIT = 13;
	localparam logic [15:0] SETUP_RST = 16'h0000;
	localparam logic [15:0] FIRST_BIT = 16'h8000;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [7:0] TASK_PWR = 8'h01;
	localparam logic [7:0] TASK_SCH0 = 8'h02;
	localparam logic [7:0] TASK_IO0 = 8'h64;
	typedef struct packed {
		logic valid;
		logic [7:0] task_num;
	} itd_disp_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_PWR = 3'b100
	} itd_state_t;
endpackage
`default_nettype wire

//--- hw/itd_dispatch.sv
// Purpose: interrupt task dispatcher with power-off handling and statistics
// Assumes: requests are one-cycle pulses on clk_in; task_done_in from the CPU core
// Notes: registers over AXI4-Lite; setup bits 14 and 13 hold online-edit and error-detect enables
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module itd_dispatch
	import itd_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic op_start_in,
	input wire logic power_fail_in,
	input wire logic [31:0] io_req_in,
	input wire logic [1:0] sched_req_in,
	input wire logic ext_req_in,
	input wire logic [7:0] ext_task_in,
	input wire logic clear_pending_request_command_in,
	input wire logic [4:0] clear_io_num_in,
	input wire logic task_done_in,
	input wire logic task_error_in,
	output itd_pkg::itd_disp_t dispatch_out,
	output logic abort_out,
	output logic cpu_reset_out,
	output logic interrupt_task_error_flag_out,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Two-flop synchroniser for the supply monitor pin
	logic pf_s1_q;
	logic pf_s2_q;
	always_ff @(posedge clk_in)
	begin
		pf_s1_q <= power_fail_in;
		pf_s2_q <= pf_s1_q;
	end

	// Registers and state
	logic [15:0] setup_q;
	logic [15:0] max_time_q;
	logic [15:0] max_task_q;
	logic [15:0] err_num_q;
	logic [255:0] pend_q;
	itd_state_t state_q;
	logic [7:0] cur_task_q;
	logic [15:0] run_ticks_q;
	logic [12:0] tick_cnt_q;
	logic [15:0] ms_cnt_q;
	logic [4:0] pwr_ms_q;
	logic pf_seen_q;
	logic pf_done_q;

	// Lowest set bit in a vector slice
	function automatic logic [7:0] lowest(input logic [255:0] v, input int lo, input int hi);
		logic [7:0] r;
		r = 8'h00;
		for (int i = hi; i >= lo; i--)
		begin
			if (v[i])
				r = 8'(i);
		end
		return r;
	endfunction

	// Delay field, clamped to its legal range
	wire [7:0] delay_raw = setup_q[7:0];
	wire [4:0] delay_ms = (delay_raw > 8'(DELAY_MAX)) ? 5'(DELAY_MAX) : delay_raw[4:0];
	wire [4:0] pwr_window = 5'(CUTOFF_MS) - delay_ms;
	wire pwr_en = setup_q[EN_BIT];
	wire online_edit = setup_q[ONLINE_BIT];
	wire err_det = setup_q[ERRDET_BIT];

	// Incoming requests as a 256-bit map; shared numbers merge onto one task
	logic [255:0] req_map;
	always_comb
	begin
		req_map = '0;
		req_map[131:100] = io_req_in;
		req_map[3:2] = sched_req_in;
		if (ext_req_in)
			req_map[ext_task_in] = 1'b1;
	end

	// Pending groups and dispatch selection
	wire [255:0] io_mask = {124'h0, 32'hFFFFFFFF, 100'h0};
	wire [255:0] sch_mask = {252'h0, 4'hC};
	wire [255:0] io_pend = pend_q & io_mask;
	wire [255:0] sch_only = pend_q & sch_mask & ~io_mask;
	wire [255:0] ext_pend = pend_q & ~io_mask & ~sch_mask;
	wire any_pend = |pend_q;
	wire [7:0] pick = (|io_pend) ? lowest(io_pend, 100, 131) :
		(|ext_pend) ? lowest(ext_pend, 0, 255) : lowest(sch_only, 2, 3);
	wire running = state_q == ST_RUN;
	wire start_op = state_q == ST_IDLE && any_pend && !pf_seen_q;

	// Clear-pending removes one I/O bit
	wire [7:0] clr_idx = TASK_IO0 + 8'(clear_io_num_in);
	wire clr_ok = clear_pending_request_command_in && running;

	// Detection delay timing: ms strobe
	wire ms_tick = ms_cnt_q == 16'(MS_CYC - 1);
	wire tick = tick_cnt_q == 13'(TICK_CYC - 1);
	wire pf_fire = pf_seen_q && !pf_done_q && pwr_ms_q >= delay_ms && ms_tick;
	wire pwr_go = pf_fire && pwr_en && !online_edit;
	wire pwr_cut = state_q == ST_PWR && ms_tick && pwr_ms_q + 5'd1 >= pwr_window;

	// Pending records
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			pend_q <= '0;
		else if (op_start_in)
			pend_q <= req_map; // Request at start outlasts the clear
		else
		begin
			logic [255:0] nxt;
			nxt = pend_q;
			if (start_op)
				nxt[pick] = 1'b0;
			if (clr_ok)
				nxt[clr_idx] = 1'b0;
			nxt = nxt | req_map;
			if (running || start_op)
				nxt[running ? cur_task_q : pick] = pend_q[running ? cur_task_q : pick] & ~start_op;
			pend_q <= nxt;
		end
	end

	// Millisecond and tenth-millisecond prescalers
	always_ff @(posedge clk_in)
	begin
		if (reset_in || ms_tick)
			ms_cnt_q <= '0;
		else
			ms_cnt_q <= ms_cnt_q + 16'd1;
		if (reset_in || tick || start_op)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 13'd1;
	end

	// Power-fail sequencing
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			pf_seen_q <= 1'b0;
			pf_done_q <= 1'b0;
			pwr_ms_q <= '0;
		end
		else if (!pf_seen_q && pf_s2_q)
		begin
			pf_seen_q <= 1'b1;
			pwr_ms_q <= '0;
		end
		else if (pf_fire)
		begin
			pf_done_q <= 1'b1;
			pwr_ms_q <= '0;
		end
		else if (ms_tick && pwr_ms_q != 5'h1F)
			pwr_ms_q <= pwr_ms_q + 5'd1;
	end

	// Task state machine
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_q <= ST_IDLE;
			cur_task_q <= '0;
			abort_out <= 1'b0;
			cpu_reset_out <= 1'b0;
			dispatch_out <= '0;
		end
		else
		begin
			dispatch_out.valid <= 1'b0;
			abort_out <= 1'b0;
			cpu_reset_out <= 1'b0;
			unique case (state_q)
				ST_IDLE:
				begin
					if (pwr_go)
					begin
						state_q <= ST_PWR;
						cur_task_q <= TASK_PWR;
						dispatch_out <= '{valid: 1'b1, task_num: TASK_PWR};
					end
					else if (start_op)
					begin
						state_q <= ST_RUN;
						cur_task_q <= pick;
						dispatch_out <= '{valid: 1'b1, task_num: pick};
					end
					else if (pf_fire)
						cpu_reset_out <= 1'b1;
				end
				ST_RUN:
				begin
					if (pwr_go)
					begin
						abort_out <= 1'b1;
						state_q <= ST_PWR;
						cur_task_q <= TASK_PWR;
						dispatch_out <= '{valid: 1'b1, task_num: TASK_PWR};
					end
					else if (pf_fire)
					begin
						abort_out <= 1'b1;
						cpu_reset_out <= 1'b1;
						state_q <= ST_IDLE;
					end
					else if (task_done_in)
						state_q <= ST_IDLE;
				end
				ST_PWR:
				begin
					if (task_done_in || pwr_cut)
					begin
						abort_out <= pwr_cut && !task_done_in;
						cpu_reset_out <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Execution time and statistics
	wire ending = (state_q != ST_IDLE) && task_done_in;
	always_ff @(posedge clk_in)
	begin
		if (reset_in || op_start_in)
		begin
			run_ticks_q <= '0;
			max_time_q <= '0;
			max_task_q <= '0;
		end
		else
		begin
			if (start_op || pwr_go)
				run_ticks_q <= '0;
			else if (tick && run_ticks_q != 16'hFFFF)
				run_ticks_q <= run_ticks_q + 16'd1;
			if (ending && (run_ticks_q > max_time_q || !max_task_q[15]))
			begin
				max_time_q <= run_ticks_q;
				max_task_q <= FIRST_BIT | {8'h00, cur_task_q};
			end
		end
	end

	// Error capture; a fresh error outranks the start clear
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			interrupt_task_error_flag_out <= 1'b0;
			err_num_q <= '0;
		end
		else if (task_error_in && err_det && state_q != ST_IDLE)
		begin
			interrupt_task_error_flag_out <= 1'b1;
			err_num_q <= {4'h0, 4'h0, cur_task_q};
		end
		else if (op_start_in)
		begin
			interrupt_task_error_flag_out <= 1'b0;
			err_num_q <= '0;
		end
	end

	// AXI4-Lite write path: take address and data in either order
	logic aw_have_q;
	logic w_have_q;
	logic [3:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	wire wr_map = aw_q == A_SETUP || aw_q == A_MAXTIME || aw_q == A_MAXTASK || aw_q == A_ERRNUM;
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			setup_q <= SETUP_RST;
		end
		else
		begin
			// Readies are flops: low from their own take until the response is taken
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? RESP_OK : RESP_SLVERR;
				if (aw_q == A_SETUP)
				begin
					if (ws_q[0])
						setup_q[7:0] <= wd_q[7:0];
					if (ws_q[1])
						setup_q[15:8] <= wd_q[15:8];
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read path
	logic [15:0] rd_word;
	always_comb
	begin
		unique case (s_axi_araddr)
			A_SETUP: rd_word = setup_q;
			A_MAXTIME: rd_word = max_time_q;
			A_MAXTASK: rd_word = max_task_q;
			A_ERRNUM: rd_word = err_num_q;
			default: rd_word = 16'h0000;
		endcase
	end
	wire rd_map = s_axi_araddr == A_SETUP || s_axi_araddr == A_MAXTIME ||
		s_axi_araddr == A_MAXTASK || s_axi_araddr == A_ERRNUM;
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OK;
			s_axi_arready <= 1'b1;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0; // One read under way at a time
			s_axi_rdata <= {16'h0000, rd_word};
			s_axi_rresp <= rd_map ? RESP_OK : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- dv/itd_asserts.sv
// Purpose: port assertions for the task dispatcher
// Assumes: one clock, synchronous reset
// Notes: bound to every dispatcher instance
`timescale 1ns/1ps
`default_nettype none
module itd_asserts
	import itd_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic op_start_in,
	input wire logic task_done_in,
	input wire logic task_error_in,
	input wire itd_pkg::itd_disp_t dispatch_out,
	input wire logic abort_out,
	input wire logic cpu_reset_out,
	input wire logic interrupt_task_error_flag_out,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Task in flight, from its dispatch until done or CPU reset
	logic busy_q;
	always_ff @(posedge clk_in)
	begin
		if (reset_in || task_done_in || cpu_reset_out)
			busy_q <= 1'b0;
		else if (dispatch_out.valid)
			busy_q <= 1'b1;
	end
	// A dispatch while a task runs, and a read answer taken
	sequence s_disp_busy;
		dispatch_out.valid && busy_q;
	endsequence
	sequence s_rd_done;
		s_axi_rvalid && s_axi_rready;
	endsequence
	AST_NO_NEST: assert property (s_disp_busy |-> abort_out && dispatch_out.task_num == TASK_PWR)
		else $error("second dispatch while a task runs");
	AST_ABORT_CAUSE: assert property (abort_out |-> cpu_reset_out || (dispatch_out.valid && dispatch_out.task_num == TASK_PWR))
		else $error("abort without the power-off task");
	AST_CPU_RST_ONCE: assert property (cpu_reset_out |=> !cpu_reset_out [*8])
		else $error("cpu reset repeated");
	AST_ERR_CAUSE: assert property ($rose(interrupt_task_error_flag_out) |-> $past(task_error_in))
		else $error("error flag without a task error");
	AST_ERR_STICKY: assert property (interrupt_task_error_flag_out && !op_start_in |=> interrupt_task_error_flag_out)
		else $error("error flag dropped");
	AST_ERR_START: assert property (op_start_in && !task_error_in |=> !interrupt_task_error_flag_out)
		else $error("error flag kept over start");
	AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response waits");
	AST_R_ONCE: assert property (s_rd_done |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule
bind itd_dispatch itd_asserts u_chk (.*);
`default_nettype wire

//--- dv/itd_ext_unit.sv
// Purpose: requesting board on the rack bus
// Assumes: go_in is a one-cycle pulse
// Notes: task number line inverted between requests
`timescale 1ns/1ps
`default_nettype none
module itd_ext_unit (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] task_in,
	output logic ext_req_out = 1'h0,
	output logic [7:0] ext_task_out = 8'h0,
	output logic mem_wr_out = 1'h0
);
	logic [7:0] t_q = 8'h0;
	// Data into memory first, request one cycle later
	always @(posedge clk_in)
	begin
		mem_wr_out <= go_in;
		ext_req_out <= mem_wr_out;
		if (go_in)
			t_q <= task_in;
		ext_task_out <= mem_wr_out ? t_q : ~t_q;
	end
endmodule
`default_nettype wire

//--- dv/tb_interrupt_task_dispatcher.sv
// Purpose: self-checking bench for the task dispatcher
// Assumes: 50 MHz clock, reset held 3 cycles
// Notes: power test waits up to 1 ms for the delay grid
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_task_dispatcher;
	import itd_pkg::*;
	logic clk_in = 1'h0, reset_in = 1'h1, op_start_in = 1'h0, power_fail_in = 1'h0, ext_go = 1'h0;
	logic task_done_in = 1'h0, task_error_in = 1'h0, clear_pending_request_command_in = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] io_req_in = 32'h0, s_axi_wdata = 32'h0, d, pat;
	logic [7:0] go_task = 8'h0, t;
	logic [7:0] exp_q [4] = '{8'h07, 8'h09, 8'h02, 8'h03};
	logic [4:0] clear_io_num_in = 5'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [1:0] sched_req_in = 2'h0, rr;
	wire logic ext_req_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic abort_out, cpu_reset_out, interrupt_task_error_flag_out;
	wire logic [7:0] ext_task_in;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire itd_disp_t dispatch_out;
	integer seed = 32'hEE489C2F;
	int fails = 0, tests_run = 0, cyc = 0, nd, nr;
	itd_dispatch u_dut (.*);
	itd_ext_unit u_ext (.clk_in(clk_in), .go_in(ext_go), .task_in(go_task), .ext_req_out(ext_req_in),
		.ext_task_out(ext_task_in), .mem_wr_out());
	// Clock and hang limit
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fails++;
			finish_test;
		end
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Bus master: write and read, one at a time
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk_in);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk_in);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk_in);
	endtask
	// Request, completion and watch helpers
	task automatic ext(input logic [7:0] n);
		go_task <= n;
		ext_go <= 1'h1;
		@(posedge clk_in);
		ext_go <= 1'h0;
		@(posedge clk_in);
	endtask
	task automatic wdisp;
		do
			@(posedge clk_in);
		while (dispatch_out.valid !== 1'h1);
		t = dispatch_out.task_num;
	endtask
	task automatic pdone;
		task_done_in <= 1'h1;
		@(posedge clk_in);
		task_done_in <= 1'h0;
	endtask
	task automatic watch;
		nd = 0;
		nr = 0;
		repeat (6)
		begin
			@(posedge clk_in);
			nd += int'(dispatch_out.valid === 1'h1);
			nr += int'(cpu_reset_out === 1'h1);
		end
	endtask
	function automatic logic [7:0] first_io(input logic [31:0] p);
		for (int i = 31; i >= 0; i--)
			if (p[i])
				first_io = TASK_IO0 + 8'(i);
	endfunction
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_in);
		reset_in <= 1'h0;
		op_start_in <= 1'h1;
		@(posedge clk_in);
		op_start_in <= 1'h0;
		rd(A_SETUP);
		chk(d, 32'h0);
		rd(A_MAXTASK);
		chk(d, 32'h0);
		rd(4'h2);
		chk(32'(rr), 32'(RESP_SLVERR));
		wr(A_MAXTIME, 32'hFFFF);
		rd(A_MAXTIME);
		chk(d, 32'h0);
		pat = $unsigned($random(seed)) % 32'd11;
		wr(A_SETUP, 32'h2000 | pat);
		rd(A_SETUP);
		chk(d, 32'h2000 | pat);
		$display("registers done");
		ext(8'hC8);
		wdisp;
		chk(t, 8'hC8);
		task_error_in <= 1'h1;
		@(posedge clk_in);
		task_error_in <= 1'h0;
		@(posedge clk_in);
		chk(interrupt_task_error_flag_out, 1'h1);
		rd(A_ERRNUM);
		chk(d & 32'hFFF, 32'hC8);
		pat = 32'($random(seed)) | 32'h21;
		io_req_in <= pat;
		sched_req_in <= 2'h3;
		@(posedge clk_in);
		@(posedge clk_in);
		io_req_in <= 32'h0;
		sched_req_in <= 2'h0;
		ext(8'h09);
		ext(8'h07);
		ext(8'hC8);
		clear_pending_request_command_in <= 1'h1;
		clear_io_num_in <= 5'h5;
		@(posedge clk_in);
		clear_pending_request_command_in <= 1'h0;
		repeat (6000) @(posedge clk_in);
		pat = pat & ~32'h20;
		while (pat != 32'h0)
		begin
			pdone;
			wdisp;
			chk(t, first_io(pat));
			pat[t - TASK_IO0] = 1'h0;
		end
		foreach (exp_q[i])
		begin
			pdone;
			wdisp;
			chk(t, exp_q[i]);
		end
		pdone;
		watch;
		chk(nd, 0);
		rd(A_MAXTASK);
		chk(d, 32'h80C8);
		rd(A_MAXTIME);
		chk(d, 32'h1);
		$display("priority done");
		wr(A_SETUP, 32'hA000);
		ext(8'h32);
		wdisp;
		power_fail_in <= 1'h1;
		wdisp;
		chk(t, TASK_PWR);
		chk(abort_out, 1'h1);
		pdone;
		watch;
		chk(nr, 1);
		$display("power done");
		finish_test;
	end
endmodule
`default_nettype wire
